// ---- shared/sar_pkg.sv ----
// constants and types of the serial converter readout sequencer
package sar_pkg;
    localparam int unsigned RESULT_BITS    = 16;
    localparam logic [5:0]  ACQ_EDGES      = 6'h05;
    localparam logic [5:0]  LAST_FWD_IDX   = 6'h00;
    localparam logic [5:0]  LAST_REV_IDX   = 6'h0f;
    localparam logic [15:0] CODE_MIDSCALE  = 16'h8000;
    localparam logic [15:0] CODE_BELOW_MID = 16'h7fff;

    typedef enum logic [2:0] {
        SAR_IDLE    = 3'b000,
        SAR_ACQUIRE = 3'b001,
        SAR_NULL    = 3'b011,
        SAR_FORWARD = 3'b010,
        SAR_REVERSE = 3'b110,
        SAR_DONE    = 3'b111
    } sar_state_t;
endpackage

// ---- rtl/sar_result_reg.sv ----
// holding register for the captured conversion result
`timescale 1ns/100ps
`default_nettype none
module sar_result_reg #(
    parameter int unsigned WIDTH = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             rstn,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] loadData,
    output var  logic [WIDTH-1:0] readData
);
    if (WIDTH < 1) begin
        $error("width must be positive");
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            readData <= '0;
        end else if (load) begin
            readData <= loadData;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/sar_readout.sv ----
// readout sequencer of a 16-bit serial sampling converter, device side
// Contract
// R1 - the data output changes on each falling serial clock edge, one bit per period.
// R2 - the host samples on the rising edge, or on the falling edge if hold margin allows.
// R3 - a falling select starts conversion and transfer.
// R4 - the first five periods after select falls acquire the input with the output undriven.
// R5 - on the fifth falling clock edge the output is enabled and held low one period.
// R6 - then the 16-bit result is sent from bit fifteen down to bit zero.
// R7 - after bit zero, further clocks resend the result from bit zero up to bit fifteen; the code resends from bit one, bit zero being shared.
// R8 - after the repeated bit fifteen the output returns to high impedance.
// R9 - after the reversed stream, further clocks are ignored while select stays low.
// R10 - a new conversion needs select raised and then lowered again.
// R11 - results are unsigned straight binary.
// R12 - one step is reference over 65536; midscale 8000h, below it 7fffh, zero 0, full all ones.
// R13 - the host keeps the serial clock between 24 kHz and 2.4 MHz.
// R14 - the converter is in low power while select is high and after conversion completes.
// R15 - a rising select abandons the transfer, clears the count and floats the output.
`timescale 1ns/100ps
`default_nettype none
module sar_readout
    import sar_pkg::*;
#(
    parameter int unsigned WIDTH = RESULT_BITS
) (
    input  wire logic             ref_clk,
    input  wire logic             rstn,
    input  wire logic             selectN,
    input  wire logic             serClk,
    input  wire logic [WIDTH-1:0] sampleCode,
    output var  logic             dataOut,
    output var  logic             dataOutEn,
    output var  logic             sampling,
    output var  logic             lowPower
);
    if (WIDTH != RESULT_BITS) begin
        $error("only a 16-bit result is served");
    end

    // ------------------------------------------------------------
    // edge detection on the synchronous pin inputs
    // ------------------------------------------------------------
    // selPrev resets high: a select held low through reset is taken as a start in the first cycle after reset
    // serClk is sampled on ref_clk, so each level must last one ref_clk cycle or more
    logic selPrev;
    logic clkPrev;
    wire  selFall = selPrev && !selectN;   // [R3]
    wire  selHigh = selectN;
    wire  clkFall = clkPrev && !serClk;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            selPrev <= 1'b1;
            clkPrev <= 1'b0;
        end else begin
            selPrev <= selectN;
            clkPrev <= serClk;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    sar_state_t state;
    sar_state_t next_state;
    logic [5:0] count;
    logic [5:0] next_count;
    logic [WIDTH-1:0] result;

    // straight binary code passes unchanged; no sign or offset mapping
    // latched on the null-bit edge, so later changes of sampleCode are not seen
    wire captureNow = (state == SAR_ACQUIRE) && clkFall && (count == ACQ_EDGES - 6'h01); // [R11]

    sar_result_reg #(.WIDTH(WIDTH)) u_result (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .load     (captureNow),
        .loadData (sampleCode),
        .readData (result)
    );

    function automatic logic bitAt(input logic [WIDTH-1:0] word, input logic [5:0] idx);
        bitAt = word[idx[3:0]];
    endfunction

    always_comb begin
        next_state = state;
        next_count = count;
        if (selHigh) begin
            next_state = SAR_IDLE;                              // [R15]
            next_count = 6'h00;
        end else begin
            unique case (state)
                SAR_IDLE: begin
                    if (selFall) begin
                        next_state = SAR_ACQUIRE;               // [R3] [R10]
                        next_count = 6'h00;
                    end
                end
                SAR_ACQUIRE: begin
                    if (clkFall) begin
                        next_count = count + 6'h01;
                        if (count == ACQ_EDGES - 6'h01) begin
                            next_state = SAR_NULL;              // [R4] [R5]
                        end
                    end
                end
                SAR_NULL: begin
                    if (clkFall) begin
                        next_state = SAR_FORWARD;               // [R6]
                        next_count = LAST_REV_IDX;
                    end
                end
                SAR_FORWARD: begin
                    if (clkFall) begin
                        if (count == LAST_FWD_IDX) begin
                            next_state = SAR_REVERSE;           // [R7]
                            next_count = 6'h01;
                        end else begin
                            next_count = count - 6'h01;
                        end
                    end
                end
                SAR_REVERSE: begin
                    if (clkFall) begin
                        if (count == LAST_REV_IDX) begin
                            next_state = SAR_DONE;              // [R8]
                        end else begin
                            next_count = count + 6'h01;
                        end
                    end
                end
                SAR_DONE: begin
                    next_state = SAR_DONE;                      // [R9]
                end
                default: begin
                    next_state = SAR_IDLE;
                    next_count = 6'h00;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state <= SAR_IDLE;
            count <= 6'h00;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    // ------------------------------------------------------------
    // registered pin outputs
    // ------------------------------------------------------------
    // bit zero is shared by both streams: forward ends on it, reverse starts above it
    wire driveNext = (next_state == SAR_NULL) || (next_state == SAR_FORWARD)
                  || (next_state == SAR_REVERSE);
    wire next_dataOut = (next_state == SAR_FORWARD || next_state == SAR_REVERSE)
                      ? bitAt(result, next_count) : 1'b0;
    // a high select counts as a bit edge so the pin floats at once
    wire bitEdge = clkFall || selHigh;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dataOut   <= 1'b0;
            dataOutEn <= 1'b0;
            sampling  <= 1'b0;
            lowPower  <= 1'b1;
        end else begin
            if (bitEdge) begin
                dataOut   <= next_dataOut;                      // [R1]
                dataOutEn <= driveNext;                         // [R5] [R8] [R15]
            end
            sampling <= (next_state == SAR_ACQUIRE);            // [R4]
            lowPower <= (next_state == SAR_IDLE) || (next_state == SAR_DONE); // [R14]
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_float_on_deselect: assert property (@(posedge ref_clk) disable iff (!rstn) // [R15]
        selectN |=> !dataOutEn) else $error("output driven while deselected");
    a_quiet_in_acquire: assert property (@(posedge ref_clk) disable iff (!rstn) // [R4]
        (state == SAR_ACQUIRE) |-> !dataOutEn) else $error("output driven in acquire");
    a_null_bit_low: assert property (@(posedge ref_clk) disable iff (!rstn) // [R5]
        (state == SAR_ACQUIRE && next_state == SAR_NULL) |=> dataOutEn && !dataOut)
        else $error("null bit not low");
    a_change_on_fall: assert property (@(posedge ref_clk) disable iff (!rstn) // [R1]
        (!clkFall && !selectN) |=> $stable(dataOut)) else $error("output moved off edge");
    a_done_ignores: assert property (@(posedge ref_clk) disable iff (!rstn) // [R9]
        (state == SAR_DONE && !selectN) |=> state == SAR_DONE && !dataOutEn)
        else $error("clock acted after stream end");
    a_msb_first: assert property (@(posedge ref_clk) disable iff (!rstn) // [R6]
        (state == SAR_NULL && next_state == SAR_FORWARD) |=> dataOut == result[WIDTH-1])
        else $error("first data bit not msb");
    a_reverse_start: assert property (@(posedge ref_clk) disable iff (!rstn) // [R7]
        (state == SAR_FORWARD && next_state == SAR_REVERSE) |=> dataOut == result[1])
        else $error("reverse stream wrong start");
    a_tristate_end: assert property (@(posedge ref_clk) disable iff (!rstn) // [R8]
        (state == SAR_REVERSE && next_state == SAR_DONE) |=> !dataOutEn && lowPower)
        else $error("output not released at stream end");
    a_restart_needs_rise: assert property (@(posedge ref_clk) disable iff (!rstn) // [R10]
        (state == SAR_IDLE && !selFall) |=> state == SAR_IDLE) else $error("start without fall");
    a_null_held_low: assert property (@(posedge ref_clk) disable iff (!rstn) // [R5]
        (state == SAR_NULL) |-> dataOutEn && !dataOut) else $error("null bit not held low");
    a_power_deselect: assert property (@(posedge ref_clk) disable iff (!rstn) // [R14]
        selectN |=> lowPower) else $error("not in low power while deselected");

    c_full_stream: cover property (@(posedge ref_clk) disable iff (!rstn)
        state == SAR_REVERSE ##1 state == SAR_DONE);
    c_abort_forward: cover property (@(posedge ref_clk) disable iff (!rstn)
        state == SAR_FORWARD ##1 state == SAR_IDLE);
    c_late_clock: cover property (@(posedge ref_clk) disable iff (!rstn)
        state == SAR_DONE && clkFall && !selectN);
    c_midscale: cover property (@(posedge ref_clk) disable iff (!rstn)
        captureNow && sampleCode == CODE_MIDSCALE);                // [R12]
    c_below_mid: cover property (@(posedge ref_clk) disable iff (!rstn)
        captureNow && sampleCode == CODE_BELOW_MID);               // [R12]
endmodule
`default_nettype wire

// ---- bench/sar_host_model.sv ----
// host-side model: drives select and the serial clock, samples serial data
`timescale 1ns/100ps
`default_nettype none
module sar_host_model (
    input  wire logic ref_clk,
    input  wire logic dataOut,
    input  wire logic dataOutEn,
    output var  logic selectN,
    output var  logic serClk
);
    // ----------------------------------------
    // serial clock idles low between frames
    // ----------------------------------------
    int   halfCycles = 21; // 21 = fastest, 2083 = slowest clock rate
    int   nFall      = 0;
    logic seenEn  [1:48];
    logic seenBit [1:48];

    initial begin
        selectN = 1'b1;
        serClk  = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic open_frame();
        wait_cyc(1);
        selectN = 1'b0;
        nFall   = 0;
        wait_cyc(2);
    endtask

    task automatic close_frame();
        selectN = 1'b1;
        serClk  = 1'b0;
        wait_cyc(3);
    endtask

    task automatic pulse(input int n);
        repeat (n) begin
            serClk = 1'b1;
            wait_cyc(halfCycles);
            serClk = 1'b0;
            nFall++;
            wait_cyc(halfCycles);
            // sampled at the end of the low phase, i.e. at the next rise
            // a floating pin reads as the inverse of its last level, so an early release shows
            seenEn[nFall]  = dataOutEn;
            seenBit[nFall] = dataOutEn ? dataOut : !dataOut;
        end
    endtask
endmodule
`default_nettype wire

// ---- bench/sar_readout_tb.sv ----
// self-checking bench of the serial converter readout sequencer
`timescale 1ns/100ps
`default_nettype none
module sar_readout_tb import sar_pkg::*;;
    logic        ref_clk    = 1'b0;
    logic        rstn       = 1'b0;
    logic [15:0] sampleCode = 16'h0000;
    logic        dataOut;
    logic        dataOutEn;
    logic        sampling;
    logic        lowPower;
    logic        selectN;
    logic        serClk;
    int          num_errors = 0;
    int          n_checks   = 0;
    int          cycles     = 0;

    always #5 ref_clk = ~ref_clk;

    sar_readout #(.WIDTH(RESULT_BITS)) DUT (
        .ref_clk(ref_clk), .rstn(rstn), .selectN(selectN), .serClk(serClk),
        .sampleCode(sampleCode), .dataOut(dataOut), .dataOutEn(dataOutEn),
        .sampling(sampling), .lowPower(lowPower));

    sar_host_model host (
        .ref_clk(ref_clk), .dataOut(dataOut), .dataOutEn(dataOutEn),
        .selectN(selectN), .serClk(serClk));

    // ----------------------------------------
    // checking and closing
    // ----------------------------------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // the scenarios need about 14000 cycles; the ceiling leaves ample margin
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            summarize();
        end
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // full frame; the input code changes after capture to prove it was latched
    task automatic run_frame(input logic [15:0] code, input int half);
        logic [15:0] e;
        sampleCode      = code;
        host.halfCycles = half;
        host.open_frame();
        check("sampling", {15'h0, sampling}, 16'h0001);
        check("lowPower", {15'h0, lowPower}, 16'h0000);
        host.pulse(5);
        sampleCode = ~code;
        host.pulse(35);
        for (int k = 1; k <= 40; k++) begin
            e = (k >= 5 && k <= 36) ? 16'h0001 : 16'h0000;
            check("enable", {15'h0, host.seenEn[k]}, e);
            if (k == 5) check("null", {15'h0, host.seenBit[k]}, 16'h0000);
            else if (k > 5 && k <= 21)
                check("fwd", {15'h0, host.seenBit[k]}, {15'h0, code[21-k]});
            else if (k > 21 && k <= 36)
                check("rev", {15'h0, host.seenBit[k]}, {15'h0, code[k-21]});
        end
        check("done power", {15'h0, lowPower}, 16'h0001);
        check("acq over", {15'h0, sampling}, 16'h0000);
        host.close_frame();
        check("idle en", {15'h0, dataOutEn}, 16'h0000);
        $display("frame %h done", code);
    endtask

    // select raised inside the forward stream, then a clean restart
    task automatic t_abort();
        sampleCode = 16'h5a3c;
        host.open_frame();
        host.pulse(10);
        check("mid en", {15'h0, dataOutEn}, 16'h0001);
        host.close_frame();
        check("abort en", {15'h0, dataOutEn}, 16'h0000);
        check("abort power", {15'h0, lowPower}, 16'h0001);
        $display("abort done");
        run_frame(16'h3c5a, 21);
    endtask

    initial begin
        repeat (10) @(posedge ref_clk);
        #1;
        rstn = 1'b1;
        check("reset power", {15'h0, lowPower}, 16'h0001);
        run_frame(CODE_MIDSCALE, 21);
        run_frame(CODE_BELOW_MID, 21);
        run_frame(16'h0000, 21);
        run_frame(16'hffff, 40);
        run_frame(16'ha5c3, 40);
        t_abort();
        summarize();
    end
endmodule
`default_nettype wire
